// ### verilog/vsl_pkg.sv
package vsl_pkg;
  localparam logic [7:0] ADDR_FIELD_SYNC = 8'h08;
  localparam logic [7:0] ADDR_LUMA_FILTER = 8'h09;
  localparam logic [7:0] ADDR_BRIGHTNESS = 8'h0a;
  localparam logic [7:0] RST_FIELD_SYNC = 8'h98;
  localparam logic [7:0] RST_LUMA_FILTER = 8'h01;
  localparam logic [7:0] RST_BRIGHTNESS = 8'h80;
  localparam int POS_AUTO_FIELD = 7;
  localparam int POS_FIELD_SEL = 6;
  localparam int POS_FORCED_TOGGLE = 5;
  localparam int POS_HTC_LSB = 3;
  localparam int POS_HLOOP = 2;
  localparam int POS_VNOISE_LSB = 0;
  localparam int POS_BYPASS = 7;
  localparam int POS_COMB = 6;
  localparam int POS_EXTRA_LINE_DELAY = 5;
  localparam int POS_REMOD = 4;
  localparam int POS_SHARP_LSB = 0;
  localparam logic [1:0] HTC_TV = 2'h0;
  localparam logic [1:0] HTC_VTR = 2'h1;
  localparam logic [1:0] HTC_RESERVED = 2'h2;
  localparam logic [1:0] HTC_FAST = 2'h3;
  localparam logic [3:0] SHARP_PLAIN = 4'h0;
  localparam logic [3:0] SHARP_NOTCH_MIN = 4'hd;

  typedef enum logic [1:0] {
    VN_NORMAL, VN_FAST, VN_FREE, VN_BYPASS
  } vnoise_mode_t;

  typedef enum logic [1:0] {
    LF_TRAP, LF_COMB, LF_BYPASS
  } luma_filter_sel_t;

  typedef enum logic [1:0] {
    SH_PLAIN, SH_PEAK, SH_LOWPASS
  } sharp_kind_t;

  typedef struct packed {
    logic auto_field_detect;
    logic field_is_60hz;
    logic forced_field_toggle;
    logic [1:0] horiz_time_constant;
    logic htc_reserved;
    logic horiz_loop_open;
    vnoise_mode_t vert_noise_mode;
  } sync_ctrl_t;

  typedef struct packed {
    luma_filter_sel_t filter_sel;
    logic extra_line_delay;
    logic [1:0] extra_lines;
    logic remod_bandwidth_wide;
    sharp_kind_t sharp_kind;
    logic [2:0] sharp_step;
    logic sharp_notch;
    logic [7:0] brightness_offset_value;
  } luma_ctrl_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_t;
endpackage : vsl_pkg

// ### verilog/luma_decode.sv
`timescale 1ns/1ps
module luma_decode (
  input wire logic [7:0] i_luma_reg,
  input wire logic [7:0] i_bright_reg,
  input wire logic i_pal_lines,
  output vsl_pkg::luma_ctrl_t o_luma
);
  import vsl_pkg::*;
  logic [3:0] sharp;
  always_comb begin
    sharp = i_luma_reg[POS_SHARP_LSB +: 4];
    o_luma = '0;
    if (i_luma_reg[POS_BYPASS]) begin
      o_luma.filter_sel = LF_BYPASS;
    end else if (i_luma_reg[POS_COMB]) begin
      o_luma.filter_sel = LF_COMB;
    end else begin
      o_luma.filter_sel = LF_TRAP;
    end
    o_luma.extra_line_delay = i_luma_reg[POS_EXTRA_LINE_DELAY];
    if (i_luma_reg[POS_EXTRA_LINE_DELAY] && (o_luma.filter_sel != LF_COMB)) begin
      o_luma.extra_lines = i_pal_lines ? 2'h2 : 2'h1;
    end
    o_luma.remod_bandwidth_wide = i_luma_reg[POS_REMOD];
    if (sharp == SHARP_PLAIN) begin
      o_luma.sharp_kind = SH_PLAIN;
    end else if (!sharp[3]) begin
      o_luma.sharp_kind = SH_PEAK;
    end else begin
      o_luma.sharp_kind = SH_LOWPASS;
    end
    o_luma.sharp_step = sharp[2:0];
    o_luma.sharp_notch = (sharp >= SHARP_NOTCH_MIN);
    o_luma.brightness_offset_value = i_bright_reg;
  end
endmodule : luma_decode

// ### verilog/video_sync_luma_control.sv
`timescale 1ns/1ps
// Operation
// - auto field detect set: detect standard; clear: use field select bit
// - field select 0 is 50 Hz/625, 1 is 60 Hz/525, manual only
// - forced toggle makes parity toggle every field, else interlaced only
// - time constant 00 TV, 01 VTR, 11 fast lock, 10 reserved
// - horizontal loop bit 1 opens PLL, frequency fixed
// - noise field 00 normal, 01 fast, 10 free running, 11 bypass
// - bypass bit 1 bypasses chroma trap or comb filter
// - comb bit chooses trap (0) or adaptive comb (1) when not bypassed
// - line delay bit adds one NTSC or two PAL lines without comb
// - remodulation bit chooses narrow or wide chroma notch
// - sharpness 0001..0111 peaking at 4.1 MHz, falling boost
// - sharpness 0000 plain, 1xxx lowpass, 1101..1111 add notches
// - brightness byte sets luma offset, 128 nominal
// - registers at 08H, 09H, 0AH, eight bits each
module video_sync_luma_control (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input vsl_pkg::reg_req_t i_req,
  input wire logic i_req_valid,
  input wire logic i_detected_60hz,
  input wire logic i_source_interlaced,
  input wire logic i_field_pulse,
  output logic [7:0] o_rd_data,
  output logic o_rd_hit,
  output vsl_pkg::sync_ctrl_t o_sync,
  output vsl_pkg::luma_ctrl_t o_luma,
  output logic o_field_parity
);
  import vsl_pkg::*;

  logic [7:0] sync_reg, sync_next;
  logic [7:0] luma_reg, luma_next;
  logic [7:0] bright_reg, bright_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic rd_hit_reg, rd_hit_next;
  logic [1:0] det_sync_reg, det_sync_next;
  logic [1:0] ilace_sync_reg, ilace_sync_next;
  logic [2:0] field_sync_reg, field_sync_next;
  logic parity_reg, parity_next;
  sync_ctrl_t sync_out_reg, sync_out_next;
  luma_ctrl_t luma_out_reg, luma_out_next;
  luma_ctrl_t luma_dec;

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
    is_addr = (a == ref_a);
  endfunction : is_addr

  // register writes
  always_comb begin
    sync_next = sync_reg;
    luma_next = luma_reg;
    bright_next = bright_reg;
    if (i_req_valid && i_req.wr) begin
      if (is_addr(i_req.addr, ADDR_FIELD_SYNC)) begin
        sync_next = i_req.data;
      end
      if (is_addr(i_req.addr, ADDR_LUMA_FILTER)) begin
        luma_next = i_req.data;
      end
      if (is_addr(i_req.addr, ADDR_BRIGHTNESS)) begin
        bright_next = i_req.data;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sync_reg <= RST_FIELD_SYNC;
      luma_reg <= RST_LUMA_FILTER;
      bright_reg <= RST_BRIGHTNESS;
    end else begin
      sync_reg <= sync_next;
      luma_reg <= luma_next;
      bright_reg <= bright_next;
    end
  end

  // register reads: data holds until the next read, hit lasts one cycle
  always_comb begin
    rd_data_next = rd_data_reg;
    rd_hit_next = 1'b0;
    if (i_req_valid && !i_req.wr) begin
      rd_hit_next = is_addr(i_req.addr, ADDR_FIELD_SYNC) |
                    is_addr(i_req.addr, ADDR_LUMA_FILTER) |
                    is_addr(i_req.addr, ADDR_BRIGHTNESS);
      if (is_addr(i_req.addr, ADDR_FIELD_SYNC)) begin
        rd_data_next = sync_reg;
      end else if (is_addr(i_req.addr, ADDR_LUMA_FILTER)) begin
        rd_data_next = luma_reg;
      end else if (is_addr(i_req.addr, ADDR_BRIGHTNESS)) begin
        rd_data_next = bright_reg;
      end else begin
        // unmapped reads return zero and raise no hit
        rd_data_next = 8'h00;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rd_data_reg <= 8'h00;
      rd_hit_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_hit_reg <= rd_hit_next;
    end
  end

  // level inputs from the video front end, two flops each
  always_comb begin
    det_sync_next = {det_sync_reg[0], i_detected_60hz};
    ilace_sync_next = {ilace_sync_reg[0], i_source_interlaced};
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      det_sync_reg <= 2'h0;
      ilace_sync_reg <= 2'h0;
    end else begin
      det_sync_reg <= det_sync_next;
      ilace_sync_reg <= ilace_sync_next;
    end
  end

  // field pulse: two flops, a third keeps the old level so one edge toggles once
  always_comb begin
    field_sync_next = {field_sync_reg[1:0], i_field_pulse};
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      field_sync_reg <= 3'h0;
    end else begin
      field_sync_reg <= field_sync_next;
    end
  end

  // sync control decode
  always_comb begin
    sync_out_next = '0;
    sync_out_next.auto_field_detect = sync_reg[POS_AUTO_FIELD];
    if (sync_reg[POS_AUTO_FIELD]) begin
      sync_out_next.field_is_60hz = det_sync_reg[1];
    end else begin
      sync_out_next.field_is_60hz = sync_reg[POS_FIELD_SEL];
    end
    sync_out_next.forced_field_toggle = sync_reg[POS_FORCED_TOGGLE];
    sync_out_next.horiz_time_constant = sync_reg[POS_HTC_LSB +: 2];
    sync_out_next.htc_reserved = (sync_reg[POS_HTC_LSB +: 2] == HTC_RESERVED);
    sync_out_next.horiz_loop_open = sync_reg[POS_HLOOP];
    sync_out_next.vert_noise_mode = vnoise_mode_t'(sync_reg[POS_VNOISE_LSB +: 2]);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sync_out_reg <= '0;
    end else begin
      sync_out_reg <= sync_out_next;
    end
  end

  // field parity
  always_comb begin
    parity_next = parity_reg;
    if (field_sync_reg[1] && !field_sync_reg[2] &&
        (sync_reg[POS_FORCED_TOGGLE] || ilace_sync_reg[1])) begin
      parity_next = !parity_reg;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      parity_reg <= 1'b0;
    end else begin
      parity_reg <= parity_next;
    end
  end

  // line count follows the registered standard, so it settles one cycle later

  luma_decode u_luma_decode (
    .i_luma_reg(luma_reg),
    .i_bright_reg(bright_reg),
    .i_pal_lines(!sync_out_reg.field_is_60hz),
    .o_luma(luma_dec)
  );

  always_comb begin
    luma_out_next = luma_dec;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      luma_out_reg <= '0;
    end else begin
      luma_out_reg <= luma_out_next;
    end
  end

  assign o_rd_data = rd_data_reg;
  assign o_rd_hit = rd_hit_reg;
  assign o_sync = sync_out_reg;
  assign o_luma = luma_out_reg;
  assign o_field_parity = parity_reg;
endmodule : video_sync_luma_control

// ### verification/vsl_host.sv
`timescale 1ns/1ps
module vsl_host (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_hit,
  output vsl_pkg::reg_req_t o_req,
  output logic o_req_valid
);
  import vsl_pkg::*;
  initial begin
    o_req = '0;
    o_req_valid = 1'b0;
  end
  // one request; q returns the byte written, or the byte read
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic h);
    logic [7:0] dd;
    dd = d;
    // fast noise mode with auto detect off
    if (w && a == ADDR_FIELD_SYNC && dd[1:0] == 2'h1) dd[7] = 1'b0;
    @(posedge i_sys_clk);
    o_req <= '{wr: w, addr: a, data: dd};
    o_req_valid <= 1'b1;
    @(posedge i_sys_clk);
    o_req_valid <= 1'b0;
    o_req <= ~o_req;
    #1;
    q = w ? dd : i_rd_data;
    h = i_rd_hit;
  endtask : xfer
endmodule : vsl_host

// ### verification/vsl_asserts.sv
`timescale 1ns/1ps
module vsl_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input vsl_pkg::reg_req_t i_req,
  input wire logic i_req_valid,
  input wire logic o_rd_hit,
  input vsl_pkg::sync_ctrl_t o_sync,
  input vsl_pkg::luma_ctrl_t o_luma
);
  import vsl_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic ws;
  logic wl;
  assign ws = i_req_valid && i_req.wr && i_req.addr == ADDR_FIELD_SYNC;
  assign wl = i_req_valid && i_req.wr && i_req.addr == ADDR_LUMA_FILTER;
  a_rd_hit_map: assert property (o_rd_hit |-> $past(i_req_valid && !i_req.wr
    && i_req.addr inside {[8'h08:8'h0a]})) else $error("hit without mapped read");
  a_auto_bit: assert property (ws |-> ##2 o_sync.auto_field_detect == $past(i_req.data[7], 2))
    else $error("auto detect bit");
  a_manual_std: assert property (ws && !i_req.data[7] |-> ##2
    o_sync.field_is_60hz == $past(i_req.data[6], 2)) else $error("manual standard");
  a_toggle_bit: assert property (ws |-> ##2 o_sync.forced_field_toggle == $past(i_req.data[5], 2))
    else $error("forced toggle");
  a_htc_field: assert property (ws |-> ##2 {o_sync.horiz_time_constant, o_sync.htc_reserved} ==
    {$past(i_req.data[4:3], 2), $past(i_req.data[4:3], 2) == HTC_RESERVED}) else $error("htc");
  a_loop_open: assert property (ws |-> ##2 o_sync.horiz_loop_open == $past(i_req.data[2], 2))
    else $error("loop bit");
  a_vnoise_mode: assert property (ws |-> ##2 o_sync.vert_noise_mode == $past(i_req.data[1:0], 2))
    else $error("noise mode");
  a_bypass_sel: assert property (wl && i_req.data[7] |-> ##2 o_luma.filter_sel == LF_BYPASS)
    else $error("bypass");
  a_comb_sel: assert property (wl && i_req.data[7:6] == 2'h1 |-> ##2 o_luma.filter_sel == LF_COMB)
    else $error("comb");
  a_remod_bit: assert property (wl |-> ##2 o_luma.remod_bandwidth_wide == $past(i_req.data[4], 2))
    else $error("remod");
  a_bright_val: assert property (i_req_valid && i_req.wr && i_req.addr == ADDR_BRIGHTNESS |-> ##2
    o_luma.brightness_offset_value == $past(i_req.data, 2)) else $error("brightness");
endmodule : vsl_asserts
bind video_sync_luma_control vsl_asserts chk (.i_sys_clk, .i_rst_n, .i_req, .i_req_valid,
  .o_rd_hit, .o_sync, .o_luma);

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  import vsl_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic det = 1'b0;
  logic intl = 1'b0;
  logic fld = 1'b0;
  reg_req_t req;
  logic req_valid, rd_hit, parity, h, p;
  logic [7:0] rd_data, q, d, a;
  sync_ctrl_t sync;
  luma_ctrl_t luma;
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;
  always #4 i_sys_clk = ~i_sys_clk;
  video_sync_luma_control uut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req(req),
    .i_req_valid(req_valid), .i_detected_60hz(det), .i_source_interlaced(intl),
    .i_field_pulse(fld), .o_rd_data(rd_data), .o_rd_hit(rd_hit), .o_sync(sync),
    .o_luma(luma), .o_field_parity(parity));
  vsl_host host (.i_sys_clk(i_sys_clk), .i_rd_data(rd_data), .i_rd_hit(rd_hit),
    .o_req(req), .o_req_valid(req_valid));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic final_report;
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  function automatic logic [7:0] rst_val(input int i);
    return i == 0 ? RST_FIELD_SYNC : i == 1 ? RST_LUMA_FILTER :
      i == 2 ? RST_BRIGHTNESS : 8'h00;
  endfunction : rst_val
  function automatic logic [7:0] kind(input logic [3:0] c);
    return c == 4'h0 ? 8'(SH_PLAIN) : c[3] ? 8'(SH_LOWPASS) : 8'(SH_PEAK);
  endfunction : kind
  task automatic wr_wait(input logic [7:0] ad, input logic [7:0] dv);
    host.xfer(1'b1, ad, dv, d, h);
    repeat (6) @(posedge i_sys_clk);
  endtask : wr_wait
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    void'($urandom(42));
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      host.xfer(1'b0, 8'h08 + 8'(i), 8'h00, q, h);
      chk("rd_data", rst_val(i), q);
      chk("rd_hit", 8'(i < 3), 8'(h));
    end
    for (int i = 0; i < 30; i++) begin
      @(posedge i_sys_clk);
      a = 8'h08 + 8'($urandom_range(2));
      det <= 1'($urandom);
      intl <= 1'($urandom);
      host.xfer(1'b1, a, 8'($urandom), d, h);
      host.xfer(1'b0, a, 8'h00, q, h);
      chk("readback", d, q);
    end
    wr_wait(ADDR_FIELD_SYNC, 8'h18);
    for (int c = 0; c < 16; c++) begin
      wr_wait(ADDR_LUMA_FILTER, 8'h20 | 8'(c));
      chk("sharp_kind", kind(4'(c)), 8'(luma.sharp_kind));
      chk("sharp_notch", 8'(c >= 13), 8'(luma.sharp_notch));
      chk("sharp_step", 8'(c & 7), 8'(luma.sharp_step));
      chk("extra_lines", 8'h02, 8'(luma.extra_lines));
      chk("extra_line_delay", 8'h01, 8'(luma.extra_line_delay));
    end
    wr_wait(ADDR_FIELD_SYNC, 8'h58);
    chk("extra_lines", 8'h01, 8'(luma.extra_lines));
    wr_wait(ADDR_LUMA_FILTER, 8'h60);
    chk("extra_lines", 8'h00, 8'(luma.extra_lines));
    chk("filter_sel", 8'(LF_COMB), 8'(luma.filter_sel));
    wr_wait(ADDR_LUMA_FILTER, 8'ha0);
    chk("extra_lines", 8'h01, 8'(luma.extra_lines));
    chk("filter_sel", 8'(LF_BYPASS), 8'(luma.filter_sel));
    for (int b = 0; b < 2; b++) begin
      det <= 1'(b);
      wr_wait(ADDR_FIELD_SYNC, 8'h98);
      chk("field_is_60hz", 8'(b), 8'(sync.field_is_60hz));
    end
    for (int i = 0; i < 3; i++) begin
      intl <= (i == 2);
      wr_wait(ADDR_FIELD_SYNC, i == 0 ? 8'hb8 : 8'h98);
      p = parity;
      fld <= 1'b1;
      repeat (6) @(posedge i_sys_clk);
      fld <= 1'b0;
      repeat (6) @(posedge i_sys_clk);
      chk("parity", 8'(p ^ (i != 1)), 8'(parity));
    end
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      host.xfer(1'b0, 8'h08 + 8'(i), 8'h00, q, h);
      chk("rd_data", rst_val(i), q);
    end
    final_report();
  end
endmodule : tb
